// ===== rtl/csw_pkg.sv
// constants, types and helpers of the system clock switch controller
// assumes one 250 MHz controller clock and synchronous inputs
package csw_pkg;

  // unlock keys
  localparam logic [7:0] CSW_KEY_HI1 = 8'h78;
  localparam logic [7:0] CSW_KEY_HI2 = 8'h9a;
  localparam logic [7:0] CSW_KEY_LO1 = 8'h46;
  localparam logic [7:0] CSW_KEY_LO2 = 8'h57;

  // osc_control_reg field positions
  localparam int CSW_CURRENT_SOURCE_FIELD_LSB = 12;
  localparam int CSW_NEXT_SOURCE_FIELD_LSB = 8;
  localparam int CSW_SWLOCK_BIT = 7;
  localparam int CSW_PLLLOCK_BIT = 5;
  localparam int CSW_CF_BIT = 3;
  localparam int CSW_SWITCH_REQUEST_BIT_BIT = 0;
  localparam int CSW_SRC_W = 3;
  localparam int CSW_NSRC = 8;

  // source codes and groups
  localparam logic [2:0] CSW_SRC_FRC = 3'h0;
  localparam logic [2:0] CSW_SRC_LOW_POWER_RC_OSC = 3'h5;
  localparam logic [2:0] CSW_CURRENT_SOURCE_FIELD_RST = 3'h0;
  localparam logic [2:0] CSW_NEXT_SOURCE_FIELD_RST = 3'h0;
  localparam logic [7:0] CSW_XTAL_SRCS = 8'h1c;
  localparam logic [7:0] CSW_PLL_SRCS = 8'h0a;

  // switching_config_field codes
  localparam logic [1:0] CSW_CFG_SW_ONLY = 2'h1;
  localparam logic [1:0] CSW_CFG_SW_FAIL_SAFE_MONITOR = 2'h0;
  localparam int CSW_CFG_DIS_BIT = 1;

  // timing
  localparam int CSW_CLK_MHZ = 250;
  localparam int CSW_OSCD_NS = 1000;
  localparam int CSW_OSCD_CYC = (CSW_OSCD_NS * CSW_CLK_MHZ + 999) / 1000;
  localparam int CSW_OST_CYC = 1024;
  localparam int CSW_CNT_W = 16;

  typedef enum logic [5:0] {
    CSW_IDLE     = 6'b000001,
    CSW_CHECK    = 6'b000010,
    CSW_WAIT_OSC = 6'b000100,
    CSW_WAIT_PLL = 6'b001000,
    CSW_SWITCH   = 6'b010000,
    CSW_SPARE    = 6'b100000
  } csw_state_t;

  typedef enum logic [2:0] {
    CSW_UNL_LOCKED = 3'b001,
    CSW_UNL_ARMED  = 3'b010,
    CSW_UNL_OPEN   = 3'b100
  } csw_unl_t;

  function automatic logic [7:0] csw_onehot(input logic [2:0] src);
    csw_onehot = 8'h01 << src;
  endfunction

  function automatic logic csw_is_xtal(input logic [2:0] src);
    csw_is_xtal = CSW_XTAL_SRCS[src];
  endfunction

  function automatic logic csw_uses_pll(input logic [2:0] src);
    csw_uses_pll = CSW_PLL_SRCS[src];
  endfunction

endpackage

// ===== rtl/csw_tmr_if.sv
// handshake between the switch controller and its start-up timer
// both ends on the controller clock
`timescale 1ns/1ps
interface csw_tmr_if;
  logic start;
  logic clear;
  logic running;
  logic done;
  modport ctrl (output start, output clear, output running, input done);
  modport tmr (input start, input clear, input running, output done);
endinterface

// ===== rtl/csw_unlock.sv
// two-write key sequencer opening one byte for one instruction
// assumes every byte write comes with an instruction strobe
`timescale 1ns/1ps
module csw_unlock
  import csw_pkg::*;
#(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // byte write
  input wire logic i_instr,
  input wire logic i_wr,
  input wire logic [7:0] i_data,
  // window
  output logic o_open
);
  csw_unl_t state_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= CSW_UNL_LOCKED;
    end else if (i_instr) begin
      if (!i_wr || state_q == CSW_UNL_OPEN) begin
        state_q <= CSW_UNL_LOCKED;
      end else if (state_q == CSW_UNL_ARMED && i_data == KEY2) begin
        state_q <= CSW_UNL_OPEN;
      end else if (i_data == KEY1) begin
        state_q <= CSW_UNL_ARMED;
      end else begin
        state_q <= CSW_UNL_LOCKED;
      end
    end
  end

  assign o_open = (state_q == CSW_UNL_OPEN);

  window_one_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_open && i_instr) |=> !o_open)
    else $error("unlock window outlived one instruction");
endmodule // csw_unlock

// ===== rtl/csw_start_tmr.sv
// crystal start-up delay then oscillator start timer
// clear stops and resets the count at once
`timescale 1ns/1ps
module csw_start_tmr
  import csw_pkg::*;
#(
  parameter int OSCD_CYC = CSW_OSCD_CYC,
  parameter int OST_CYC = CSW_OST_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // controller side
  csw_tmr_if.tmr tif
);
  logic [CSW_CNT_W-1:0] cnt_q;
  logic [1:0] phase_q;
  logic busy_q;

  always_ff @(posedge i_clk) begin
    if (i_reset || tif.clear) begin
      cnt_q <= '0;
      phase_q <= 2'h0;
      busy_q <= 1'b0;
    end else if (tif.start) begin
      cnt_q <= '0;
      phase_q <= 2'h0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (phase_q == 2'h0) begin
        if (cnt_q == CSW_CNT_W'(OSCD_CYC - 1)) begin
          phase_q <= 2'h1;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (phase_q == 2'h1) begin
        if (tif.running) begin
          phase_q <= 2'h2;
        end
      end else if (phase_q == 2'h2) begin
        if (cnt_q == CSW_CNT_W'(OST_CYC - 1)) begin
          phase_q <= 2'h3;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign tif.done = busy_q && (phase_q == 2'h3);
endmodule // csw_start_tmr

// ===== rtl/csw_ctrl.sv
// system clock switch controller: control register, unlock, switch sequence
// runs on the current system clock; inputs synchronous; reset is power-on
`timescale 1ns/1ps
module csw_ctrl
  import csw_pkg::*;
#(
  parameter int OSCD_CYC = CSW_OSCD_CYC,
  parameter int OST_CYC = CSW_OST_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // software byte writes
  input wire logic i_instr,
  input wire logic i_wr_hi,
  input wire logic i_wr_lo,
  input wire logic [7:0] i_wr_data,
  // configuration
  input wire logic [1:0] i_switching_cfg,
  input wire logic i_wdt_en,
  // system events
  input wire logic i_sleep_req,
  input wire logic i_clk_fail,
  // oscillator status
  input wire logic [CSW_NSRC-1:0] i_osc_running,
  input wire logic i_pll_lock,
  // register and control outputs
  output logic [15:0] o_osc_control_reg,
  output logic [CSW_NSRC-1:0] o_osc_enable,
  output logic o_pll_enable,
  output logic [CSW_SRC_W-1:0] o_sys_clk_sel,
  output logic o_switch_busy,
  output logic o_sleep_go
);
  csw_state_t state_q;
  csw_state_t state_d;
  logic [2:0] current_source_field_q;
  logic [2:0] next_source_field_q;
  logic switch_request_bit_q;
  logic cf_q;
  logic lock_q;
  logic swlock_q;
  logic [CSW_NSRC-1:0] osc_en_q;
  logic [CSW_NSRC-1:0] osc_en_d;
  logic pll_en_q;
  logic sleep_go_q;
  logic hi_open;
  logic lo_open;
  logic hi_acc;
  logic lo_acc;
  logic sw_allowed;
  logic keep_low_power_rc_osc;
  logic fail;
  logic req_set;
  logic req_clr;
  logic abort;
  logic busy;
  logic redundant;
  logic valid_start;
  logic new_ready;
  logic switch_done;

  csw_tmr_if tif ();

  csw_unlock #(
    .KEY1(CSW_KEY_HI1),
    .KEY2(CSW_KEY_HI2)
  ) u_unl_hi (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_instr(i_instr),
    .i_wr(i_wr_hi),
    .i_data(i_wr_data),
    .o_open(hi_open)
  );

  csw_unlock #(
    .KEY1(CSW_KEY_LO1),
    .KEY2(CSW_KEY_LO2)
  ) u_unl_lo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_instr(i_instr),
    .i_wr(i_wr_lo),
    .i_data(i_wr_data),
    .o_open(lo_open)
  );

  csw_start_tmr #(
    .OSCD_CYC(OSCD_CYC),
    .OST_CYC(OST_CYC)
  ) u_tmr (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .tif(tif)
  );

  // configuration decode
  always_comb begin
    sw_allowed = !i_switching_cfg[CSW_CFG_DIS_BIT];
    if (swlock_q && i_switching_cfg == CSW_CFG_SW_ONLY) begin
      sw_allowed = 1'b0;
    end
    keep_low_power_rc_osc = i_wdt_en || (i_switching_cfg == CSW_CFG_SW_FAIL_SAFE_MONITOR);
    fail = i_clk_fail && (i_switching_cfg == CSW_CFG_SW_FAIL_SAFE_MONITOR);
  end

  // software access decode
  always_comb begin
    hi_acc = i_instr && i_wr_hi && hi_open && !switch_request_bit_q;
    lo_acc = i_instr && i_wr_lo && lo_open;
    req_set = lo_acc && i_wr_data[CSW_SWITCH_REQUEST_BIT_BIT] && !switch_request_bit_q && sw_allowed;
    req_clr = lo_acc && !i_wr_data[CSW_SWITCH_REQUEST_BIT_BIT] && switch_request_bit_q;
    abort = req_clr || i_sleep_req || fail;
    busy = (state_q != CSW_IDLE);
  end

  // switch sequence decode
  always_comb begin
    redundant = (state_q == CSW_CHECK) && (next_source_field_q == current_source_field_q) && !abort;
    valid_start = (state_q == CSW_CHECK) && (next_source_field_q != current_source_field_q) && !abort;
    if (csw_is_xtal(next_source_field_q)) begin
      new_ready = tif.done;
    end else begin
      new_ready = i_osc_running[next_source_field_q];
    end
    switch_done = (state_q == CSW_SWITCH) && !abort;
  end

  // timer hookup
  assign tif.start = valid_start && csw_is_xtal(next_source_field_q);
  assign tif.clear = abort && busy;
  assign tif.running = i_osc_running[next_source_field_q];

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      CSW_IDLE: begin
        if (switch_request_bit_q && !abort) begin
          state_d = CSW_CHECK;
        end
      end
      CSW_CHECK: begin
        if (redundant) begin
          state_d = CSW_IDLE;
        end else begin
          state_d = CSW_WAIT_OSC;
        end
      end
      CSW_WAIT_OSC: begin
        if (new_ready && csw_uses_pll(next_source_field_q)) begin
          state_d = CSW_WAIT_PLL;
        end else if (new_ready) begin
          state_d = CSW_SWITCH;
        end
      end
      CSW_WAIT_PLL: begin
        if (i_pll_lock) begin
          state_d = CSW_SWITCH;
        end
      end
      CSW_SWITCH: begin
        state_d = CSW_IDLE;
      end
      default: begin
        state_d = CSW_IDLE;
      end
    endcase
    if (abort) begin
      state_d = CSW_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= CSW_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // switch request bit
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      switch_request_bit_q <= 1'b0;
    end else if (fail || i_sleep_req) begin
      switch_request_bit_q <= 1'b0;
    end else if (redundant || switch_done || req_clr) begin
      switch_request_bit_q <= 1'b0;
    end else if (req_set) begin
      switch_request_bit_q <= 1'b1;
    end
  end

  // next source field, writable only between switches
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      next_source_field_q <= CSW_NEXT_SOURCE_FIELD_RST;
    end else if (hi_acc) begin
      next_source_field_q <= i_wr_data[CSW_SRC_W-1:0];
    end
  end

  // current source field
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      current_source_field_q <= CSW_CURRENT_SOURCE_FIELD_RST;
    end else if (fail) begin
      current_source_field_q <= CSW_SRC_FRC;
    end else if (switch_done) begin
      current_source_field_q <= next_source_field_q;
    end
  end

  // clock fail flag, a failure wins over the clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cf_q <= 1'b0;
    end else if (fail) begin
      cf_q <= 1'b1;
    end else if (valid_start) begin
      cf_q <= 1'b0;
    end
  end

  // pll lock status
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lock_q <= 1'b0;
    end else if (valid_start) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= i_pll_lock && pll_en_q;
    end
  end

  // write-once switch lock
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      swlock_q <= 1'b0;
    end else if (lo_acc && i_wr_data[CSW_SWLOCK_BIT]) begin
      swlock_q <= 1'b1;
    end
  end

  // oscillator enables, make before break
  always_comb begin
    osc_en_d = osc_en_q;
    if (valid_start) begin
      osc_en_d = osc_en_q | csw_onehot(next_source_field_q);
    end
    if (switch_done) begin
      osc_en_d = (osc_en_q & ~csw_onehot(current_source_field_q)) | csw_onehot(next_source_field_q);
    end
    if (abort && busy && state_q != CSW_CHECK) begin
      osc_en_d = (osc_en_q & ~csw_onehot(next_source_field_q)) | csw_onehot(current_source_field_q);
    end
    if (fail) begin
      osc_en_d = osc_en_d | csw_onehot(CSW_SRC_FRC);
    end
    if (keep_low_power_rc_osc) begin
      osc_en_d = osc_en_d | csw_onehot(CSW_SRC_LOW_POWER_RC_OSC);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      osc_en_q <= csw_onehot(CSW_CURRENT_SOURCE_FIELD_RST);
    end else begin
      osc_en_q <= osc_en_d;
    end
  end

  // pll enable
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pll_en_q <= csw_uses_pll(CSW_CURRENT_SOURCE_FIELD_RST);
    end else if (fail) begin
      pll_en_q <= 1'b0;
    end else if (abort && busy) begin
      pll_en_q <= csw_uses_pll(current_source_field_q);
    end else if (valid_start && csw_uses_pll(next_source_field_q)) begin
      pll_en_q <= 1'b1;
    end else if (switch_done) begin
      pll_en_q <= csw_uses_pll(next_source_field_q);
    end
  end

  // sleep goes ahead one cycle after the abort
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sleep_go_q <= 1'b0;
    end else begin
      sleep_go_q <= i_sleep_req;
    end
  end

  assign o_osc_control_reg = {1'b0, current_source_field_q, 1'b0, next_source_field_q,
                              swlock_q, 1'b0, lock_q, 1'b0, cf_q, 2'h0, switch_request_bit_q};
  assign o_osc_enable = osc_en_q;
  assign o_pll_enable = pll_en_q;
  assign o_sys_clk_sel = current_source_field_q;
  assign o_switch_busy = (state_q != CSW_IDLE);
  assign o_sleep_go = sleep_go_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_sleep_abort;
    i_sleep_req ##1 (!switch_request_bit_q && state_q == CSW_IDLE && o_sleep_go);
  endsequence

  sequence s_switch_end;
    (state_q == CSW_SWITCH && !abort) ##1 (!switch_request_bit_q && state_q == CSW_IDLE);
  endsequence

  redundant_req_a: assert property (
    redundant |=> (!switch_request_bit_q && state_q == CSW_IDLE))
    else $error("redundant request not dropped");

  start_flags_a: assert property (
    (valid_start && !fail) |=> (!cf_q && !lock_q))
    else $error("flags not cleared at switch start");

  new_osc_on_a: assert property (
    valid_start |=> osc_en_q[$past(next_source_field_q)])
    else $error("new oscillator not enabled");

  pll_wait_a: assert property (
    (state_q == CSW_WAIT_PLL && !i_pll_lock && !abort) |=> state_q == CSW_WAIT_PLL)
    else $error("switch made without pll lock");

  switch_copy_a: assert property (
    (state_q == CSW_SWITCH && !abort) |=> (current_source_field_q == $past(next_source_field_q) && !switch_request_bit_q))
    else $error("switch did not copy source");

  switch_seq_a: assert property (
    (state_q == CSW_SWITCH && !abort) |-> s_switch_end)
    else $error("switch did not end in idle");

  low_power_rc_osc_keep_a: assert property (
    keep_low_power_rc_osc |=> osc_en_q[CSW_SRC_LOW_POWER_RC_OSC])
    else $error("low-power rc dropped");

  clock_hold_a: assert property (
    (state_q == CSW_WAIT_OSC && !fail) |=> $stable(o_sys_clk_sel))
    else $error("clock moved before source stable");

  sw_abort_a: assert property (
    (busy && req_clr) |=> (state_q == CSW_IDLE && !switch_request_bit_q && !tif.done))
    else $error("abort left switch running");

  sleep_abort_a: assert property (
    i_sleep_req |-> s_sleep_abort)
    else $error("sleep did not abort switch");

  sw_lock_a: assert property (
    swlock_q |=> swlock_q)
    else $error("switch lock cleared");

  lock_block_a: assert property (
    (swlock_q && i_switching_cfg == CSW_CFG_SW_ONLY && !switch_request_bit_q) |=> !switch_request_bit_q)
    else $error("request taken while switch lock set");

  fail_force_a: assert property (
    fail |=> (current_source_field_q == CSW_SRC_FRC && cf_q && !switch_request_bit_q))
    else $error("failure not handled");

  hi_protect_a: assert property (
    (switch_request_bit_q && i_wr_hi) |=> $stable(next_source_field_q))
    else $error("next source written during switch");
endmodule // csw_ctrl

// ===== tb/csw_ctrl_test.sv
// self-checking bench of the clock switch controller, driven through its byte writes
// assumes csw_pkg and the design files are compiled first; short start-up counts
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t: got %h exp %h", $time, (g), (e)); end end
module csw_ctrl_test import csw_pkg::*;;
  localparam int OSCD = 2;
  localparam int OST = 4;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_instr = 1'b0;
  logic i_wr_hi = 1'b0;
  logic i_wr_lo = 1'b0;
  logic [7:0] i_wr_data = 8'h00;
  logic [1:0] i_switching_cfg = 2'h1;
  logic i_wdt_en = 1'b0;
  logic i_sleep_req = 1'b0;
  logic i_clk_fail = 1'b0;
  logic [7:0] i_osc_running = 8'h01;
  logic i_pll_lock = 1'b0;
  logic [15:0] osc_reg;
  logic [7:0] osc_en;
  logic pll_en;
  logic [2:0] clk_sel;
  logic busy;
  logic sleep_go;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycle_cnt = 0;

  csw_ctrl #(.OSCD_CYC(OSCD), .OST_CYC(OST)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_instr(i_instr), .i_wr_hi(i_wr_hi),
    .i_wr_lo(i_wr_lo), .i_wr_data(i_wr_data), .i_switching_cfg(i_switching_cfg),
    .i_wdt_en(i_wdt_en), .i_sleep_req(i_sleep_req), .i_clk_fail(i_clk_fail),
    .i_osc_running(i_osc_running), .i_pll_lock(i_pll_lock), .o_osc_control_reg(osc_reg),
    .o_osc_enable(osc_en), .o_pll_enable(pll_en), .o_sys_clk_sel(clk_sel),
    .o_switch_busy(busy), .o_sleep_go(sleep_go)
  );

  always #2 i_clk = ~i_clk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge i_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // one instruction, optionally writing a byte
  task automatic wr(input logic hi, input logic lo, input logic [7:0] d);
    @(posedge i_clk);
    i_instr <= 1'b1;
    i_wr_hi <= hi;
    i_wr_lo <= lo;
    i_wr_data <= d;
    @(posedge i_clk);
    i_instr <= 1'b0;
    i_wr_hi <= 1'b0;
    i_wr_lo <= 1'b0;
  endtask

  task automatic put_hi(input logic [2:0] src);
    wr(1'b1, 1'b0, CSW_KEY_HI1);
    wr(1'b1, 1'b0, CSW_KEY_HI2);
    wr(1'b1, 1'b0, {5'h00, src});
    @(negedge i_clk);
  endtask

  task automatic put_lo(input logic [7:0] d);
    wr(1'b0, 1'b1, CSW_KEY_LO1);
    wr(1'b0, 1'b1, CSW_KEY_LO2);
    wr(1'b0, 1'b1, d);
    @(negedge i_clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (osc_reg[0] !== 1'b0 && k < 300) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(k < 300, 1'b1)
  endtask

  task automatic pulse_sleep;
    @(posedge i_clk);
    i_sleep_req <= 1'b1;
    @(posedge i_clk);
    i_sleep_req <= 1'b0;
    @(negedge i_clk);
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    `CHK(osc_reg, 16'h0000)
    `CHK({osc_en, pll_en, clk_sel, busy, sleep_go}, {8'h01, 1'b0, 3'h0, 1'b0, 1'b0})
    // locked byte, wrong key, extra instruction
    wr(1'b1, 1'b0, 8'h05);
    wr(1'b1, 1'b0, CSW_KEY_HI1);
    wr(1'b1, 1'b0, 8'h55);
    wr(1'b1, 1'b0, 8'h05);
    wr(1'b1, 1'b0, CSW_KEY_HI1);
    wr(1'b1, 1'b0, CSW_KEY_HI2);
    wr(1'b0, 1'b0, 8'h00);
    wr(1'b1, 1'b0, 8'h05);
    cyc(1);
    `CHK(osc_reg[10:8], 3'h0)
    wr(1'b0, 1'b1, CSW_KEY_LO2);
    wr(1'b0, 1'b1, 8'h01);
    cyc(2);
    `CHK(osc_reg[0], 1'b0)
    // redundant request
    put_lo(8'h01);
    `CHK(osc_reg[0], 1'b1)
    cyc(4);
    `CHK({osc_reg[0], clk_sel, busy}, {1'b0, 3'h0, 1'b0})
    // switch to low-power rc, stalled then released
    put_hi(CSW_SRC_LOW_POWER_RC_OSC);
    `CHK(osc_reg[10:8], 3'h5)
    put_lo(8'h01);
    cyc(10);
    `CHK({osc_reg[0], clk_sel, osc_en}, {1'b1, 3'h0, 8'h21})
    put_hi(3'h1);
    `CHK(osc_reg[10:8], 3'h5)
    @(posedge i_clk);
    i_osc_running <= 8'h21;
    wait_idle();
    cyc(2);
    `CHK({osc_reg[14:12], clk_sel, osc_en}, {3'h5, 3'h5, 8'h20})
    // back to fast rc, watchdog keeps low-power rc
    @(posedge i_clk);
    i_wdt_en <= 1'b1;
    put_hi(CSW_SRC_FRC);
    put_lo(8'h01);
    wait_idle();
    cyc(2);
    `CHK({clk_sel, osc_en}, {3'h0, 8'h21})
    // crystal: abort, then full start-up
    put_hi(3'h2);
    put_lo(8'h01);
    cyc(20);
    `CHK({osc_reg[0], osc_en[2], clk_sel}, {1'b1, 1'b1, 3'h0})
    put_lo(8'h00);
    cyc(2);
    `CHK({osc_reg[0], osc_en, busy, clk_sel}, {1'b0, 8'h21, 1'b0, 3'h0})
    @(posedge i_clk);
    i_osc_running <= 8'h25;
    put_lo(8'h01);
    cyc(3);
    `CHK(osc_reg[0], 1'b1)
    wait_idle();
    cyc(2);
    `CHK({clk_sel, osc_reg[14:12], osc_en}, {3'h2, 3'h2, 8'h24})
    // monitor failure forces fast rc
    @(posedge i_clk);
    i_switching_cfg <= 2'h0;
    i_clk_fail <= 1'b1;
    @(posedge i_clk);
    i_clk_fail <= 1'b0;
    @(negedge i_clk);
    `CHK({osc_reg[14:12], osc_reg[3], osc_reg[0], clk_sel}, {3'h0, 1'b1, 1'b0, 3'h0})
    // pll source waits for lock
    @(posedge i_clk);
    i_osc_running <= 8'h27;
    put_hi(3'h1);
    put_lo(8'h01);
    cyc(12);
    `CHK({osc_reg[0], osc_reg[3], osc_reg[5], pll_en}, {1'b1, 1'b0, 1'b0, 1'b1})
    `CHK(clk_sel, 3'h0)
    @(posedge i_clk);
    i_pll_lock <= 1'b1;
    wait_idle();
    cyc(1);
    `CHK({clk_sel, osc_reg[5]}, {3'h1, 1'b1})
    // sleep during a stalled switch
    @(posedge i_clk);
    i_osc_running <= 8'h07;
    put_hi(CSW_SRC_LOW_POWER_RC_OSC);
    put_lo(8'h01);
    cyc(3);
    pulse_sleep();
    `CHK({osc_reg[0], clk_sel, sleep_go, busy}, {1'b0, 3'h1, 1'b1, 1'b0})
    cyc(1);
    `CHK(sleep_go, 1'b0)
    // switch lock under switch-only config
    @(posedge i_clk);
    i_switching_cfg <= 2'h1;
    i_osc_running <= 8'h27;
    put_lo(8'h80);
    put_lo(8'h00);
    `CHK(osc_reg[7], 1'b1)
    put_lo(8'h81);
    cyc(12);
    `CHK({osc_reg[0], clk_sel}, {1'b0, 3'h1})
    // power-on reset clears the lock; config 1x blocks
    @(posedge i_clk);
    i_reset <= 1'b1;
    i_switching_cfg <= 2'h2;
    @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    `CHK({osc_reg, busy, clk_sel}, {16'h0000, 1'b0, 3'h0})
    put_hi(CSW_SRC_LOW_POWER_RC_OSC);
    put_lo(8'h01);
    cyc(10);
    `CHK({osc_reg[0], clk_sel}, {1'b0, 3'h0})
    @(posedge i_clk);
    i_switching_cfg <= 2'h1;
    put_lo(8'h01);
    wait_idle();
    cyc(1);
    `CHK(clk_sel, 3'h5)
    print_verdict();
  end
endmodule // csw_ctrl_test
